// ---- pgen_pkg.sv ----
// package: register map, field layout, reset values and timing of the test pattern generator
package pgen_pkg;

   // ****************************************
   // register indices (byte address = index * 4)
   // ****************************************
   localparam logic [7:0] REG_CTL       = 8'h01;
   localparam logic [7:0] REG_CFG       = 8'h02;
   localparam logic [7:0] REG_IDENT     = 8'h03;
   localparam logic [7:0] REG_LINE_HI   = 8'h04;
   localparam logic [7:0] REG_LINE_LO   = 8'h05;
   localparam logic [7:0] REG_BAR_HI    = 8'h06;
   localparam logic [7:0] REG_BAR_LO    = 8'h07;
   localparam logic [7:0] REG_ACT_HI    = 8'h08;
   localparam logic [7:0] REG_ACT_LO    = 8'h09;
   localparam logic [7:0] REG_TOT_HI    = 8'h0A;
   localparam logic [7:0] REG_TOT_LO    = 8'h0B;
   localparam logic [7:0] REG_PERIOD_HI = 8'h0C;
   localparam logic [7:0] REG_PERIOD_LO = 8'h0D;
   localparam logic [7:0] REG_TOP_BLANK = 8'h0E;
   localparam logic [7:0] REG_BOT_BLANK = 8'h0F;
   localparam logic [7:0] REG_COLOR0    = 8'h10;
   localparam logic [7:0] REG_STATUS    = 8'h18;
   localparam logic [7:0] REG_FIRST     = 8'h01;
   localparam logic [7:0] REG_LAST      = 8'h18;
   localparam int         COLOR_COUNT   = 8;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTL_ON_BIT     = 0;
   localparam int CFG_FIXED_BIT  = 7;
   localparam int CFG_BARS_LSB   = 4;
   localparam int CFG_BLOCK_LSB  = 0;
   localparam int IDENT_VC_LSB   = 6;
   localparam int IDENT_DT_LSB   = 0;
   localparam int STAT_RUN_BIT   = 0;
   localparam int STAT_VIDEO_BIT = 1;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_CTL       = 8'h00;
   localparam logic [7:0] RST_CFG       = 8'h33;
   localparam logic [7:0] RST_IDENT     = 8'h24;
   localparam logic [7:0] RST_LINE_HI   = 8'h07;
   localparam logic [7:0] RST_LINE_LO   = 8'h80;
   localparam logic [7:0] RST_BAR_HI    = 8'h00;
   localparam logic [7:0] RST_BAR_LO    = 8'hF0;
   localparam logic [7:0] RST_ACT_HI    = 8'h01;
   localparam logic [7:0] RST_ACT_LO    = 8'hE0;
   localparam logic [7:0] RST_TOT_HI    = 8'h02;
   localparam logic [7:0] RST_TOT_LO    = 8'h0D;
   localparam logic [7:0] RST_PERIOD_HI = 8'h0C;
   localparam logic [7:0] RST_PERIOD_LO = 8'h67;
   localparam logic [7:0] RST_TOP_BLANK = 8'h21;
   localparam logic [7:0] RST_BOT_BLANK = 8'h0A;
   localparam logic [7:0] RST_COLOR [COLOR_COUNT] =
      '{8'hAA, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h66, 8'h99};

   // ****************************************
   // timing: line period counts 10 ns units, clock is 50 ns
   // ****************************************
   localparam int          CLK_PERIOD_NS = 50;
   localparam int          LINE_UNIT_NS  = 10;
   localparam logic [16:0] UNITS_PER_CLK = 17'(CLK_PERIOD_NS / LINE_UNIT_NS);

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic        fixed_pattern_select;
      logic [1:0]  bar_count_code;
      logic [3:0]  block_bytes;
      logic [1:0]  packet_virtual_channel;
      logic [5:0]  packet_data_type;
      logic [15:0] active_line_bytes;
      logic [15:0] bar_bytes;
      logic [15:0] active_line_count;
      logic [15:0] frame_line_count;
      logic [15:0] line_period_count;
      logic [7:0]  top_blank_lines;
      logic [7:0]  bottom_blank_lines;
   } generator_config_t;

   typedef struct packed {
      logic        frame_start;
      logic        frame_end;
      logic        line_start;
      logic        data_valid;
      logic        line_end;
      logic [1:0]  virtual_channel;
      logic [5:0]  data_type;
      logic [15:0] word_count;
      logic [7:0]  data;
   } csi_out_t;

endpackage : pgen_pkg

// ---- pgen_position.sv ----
// pattern position tracker: selects which colour register feeds the current byte
`timescale 1ns/1ps
module pgen_position #(
   parameter int IDX_W = 3
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             restart_in,
   input  wire logic             step_in,
   input  wire logic             fixed_in,
   input  wire logic [1:0]       bar_code_in,
   input  wire logic [3:0]       block_bytes_in,
   input  wire logic [15:0]      bar_bytes_in,
   output logic      [IDX_W-1:0] color_idx_out
);

   logic [15:0]      run_count;
   logic [3:0]       block_pos;
   logic [IDX_W-1:0] last_bar;
   logic [3:0]       block_end;

   // 00/01/10/11 -> 1/2/4/8 bars; last index is count minus one
   always_comb begin
      case (bar_code_in)
         2'b00:   last_bar = 3'h0;
         2'b01:   last_bar = 3'h1;
         2'b10:   last_bar = 3'h3;
         default: last_bar = 3'h7;
      endcase
   end

   // an illegal block size of zero behaves as one byte
   assign block_end = (block_bytes_in == 4'h0) ? 4'h0 : block_bytes_in - 4'h1;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in || restart_in) begin
         run_count     <= 16'h0000;
         block_pos     <= 4'h0;
         color_idx_out <= '0;
      end else if (step_in) begin
         if (fixed_in) begin // [R15]
            block_pos     <= (block_pos >= block_end) ? 4'h0 : block_pos + 4'h1;
            color_idx_out <= (block_pos >= block_end) ? '0 : IDX_W'(block_pos + 4'h1);
         end else if (color_idx_out != last_bar &&
                      run_count + 16'h0001 >= bar_bytes_in) begin // [R3] [R8]
            run_count     <= 16'h0000;
            color_idx_out <= color_idx_out + 1'b1;
         end else begin
            // the last bar simply runs to the end of the line
            run_count <= run_count + 16'h0001;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_bar_limit;
      @(posedge clk_in) disable iff (!rst_n_in)
      // a new frame's settings arrive one cycle before restart clears the old index
      (!fixed_in && !restart_in) |-> color_idx_out <= last_bar;
   endproperty
   a_bar_limit: assert property (p_bar_limit) // [R3]
      else $error("bar index beyond selected bar count");

   property p_bar_advance;
      @(posedge clk_in) disable iff (!rst_n_in)
      (step_in && !restart_in && !fixed_in && color_idx_out != last_bar &&
       run_count + 16'h0001 >= bar_bytes_in)
      |=> color_idx_out == $past(color_idx_out) + 1'b1;
   endproperty
   a_bar_advance: assert property (p_bar_advance) // [R8]
      else $error("bar did not advance after its programmed length");

endmodule : pgen_position

// ---- pgen_top.sv ----
// video test pattern generator with apb register page and csi-2 packet stream output
`timescale 1ns/1ps
//
// Contract
// R1: generate only while the on bit is set; off after reset. Code: clearing the bit lets the current frame finish first.
// R2: config bit 7 picks colour bars when 0, fixed pattern when 1.
// R3: bar count code 00/01/10/11 gives 1/2/4/8 bars; reset gives eight.
// R4: fixed pattern block spans block size bytes; software writes only 1 to 15.
// R5: virtual channel field goes into every generated packet.
// R6: data type field goes into every packet; reset value is RGB888.
// R7: active line length is sixteen bits from two registers; reset 1920 bytes.
// R8: every bar but the last takes the bar length; last takes the rest.
// R9: frame carries the programmed active line count; reset 480 lines.
// R10: frame lasts the programmed total line count including blanking. Code: a total below the blank and active lines plus one is stretched to that.
// R11: each line is timed by the line period in 10 ns units. Code: a line whose bytes outlast the period ends after its last byte.
// R12: top blank lines after frame start, bottom blank lines before frame end.
// R13: colour registers give bar bytes, or successive fixed pattern bytes.
// R14: start at a frame boundary; config only changes between frames.
// R15: bars cycle in order per line; fixed block repeats across the line.
module pgen_top
   import pgen_pkg::*;
(
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             psel_in,
   input  wire logic             penable_in,
   input  wire logic             pwrite_in,
   input  wire logic [31:0]      paddr_in,
   input  wire logic [31:0]      pwdata_in,
   output logic                  pready_out,
   output logic      [31:0]      prdata_out,
   output logic                  pslverr_out,
   output pgen_pkg::csi_out_t    csi_out,
   output logic                  running_out
);
   import pgen_pkg::*;

   typedef enum logic {ST_IDLE, ST_RUN} gen_state_t;

   // ****************************************
   // register file
   // ****************************************
   logic [7:0]  regs [REG_FIRST:REG_LAST];
   logic [7:0]  reg_idx;
   logic        reg_hit;
   logic        reg_ro;
   logic        apb_access;
   logic        apb_commit;
   logic [7:0]  read_byte;
   logic [7:0]  status_byte;
   generator_config_t   live_cfg;
   generator_config_t   shadow;

   // ****************************************
   // frame engine
   // ****************************************
   gen_state_t  state;
   logic [15:0] line_idx;
   logic [16:0] line_timer;
   logic [15:0] bytes_left;
   logic        sending;
   logic        begin_line;
   logic        timer_done;
   logic        line_done;
   logic        last_line;
   logic        video_line;
   logic [15:0] video_first;
   logic [15:0] video_end;
   logic [15:0] end_line;
   logic [2:0]  color_idx;

   assign reg_idx    = paddr_in[9:2];
   assign reg_hit    = (paddr_in[1:0] == 2'b00) && (paddr_in[31:10] == 22'h0) &&
                       (reg_idx >= REG_FIRST) && (reg_idx <= REG_LAST);
   assign reg_ro     = (reg_idx == REG_STATUS);
   assign apb_access = psel_in && penable_in;
   assign apb_commit = apb_access && pready_out;

   assign status_byte = {6'h00, video_line && state == ST_RUN, state == ST_RUN};

   always_comb begin
      read_byte = 8'h00;
      if (reg_hit) begin
         read_byte = reg_ro ? status_byte : regs[reg_idx];
      end
   end

   // one wait state: pready rises in the second access cycle, data registered with it
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (apb_access && !pready_out) begin
         pready_out  <= 1'b1;
         prdata_out  <= {24'h000000, pwrite_in ? 8'h00 : read_byte};
         pslverr_out <= !reg_hit || (pwrite_in && reg_ro);
      end else begin
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         regs[REG_CTL]       <= RST_CTL; // [R1]
         regs[REG_CFG]       <= RST_CFG; // [R3]
         regs[REG_IDENT]     <= RST_IDENT; // [R6]
         regs[REG_LINE_HI]   <= RST_LINE_HI; // [R7]
         regs[REG_LINE_LO]   <= RST_LINE_LO;
         regs[REG_BAR_HI]    <= RST_BAR_HI;
         regs[REG_BAR_LO]    <= RST_BAR_LO;
         regs[REG_ACT_HI]    <= RST_ACT_HI; // [R9]
         regs[REG_ACT_LO]    <= RST_ACT_LO;
         regs[REG_TOT_HI]    <= RST_TOT_HI;
         regs[REG_TOT_LO]    <= RST_TOT_LO;
         regs[REG_PERIOD_HI] <= RST_PERIOD_HI;
         regs[REG_PERIOD_LO] <= RST_PERIOD_LO;
         regs[REG_TOP_BLANK] <= RST_TOP_BLANK;
         regs[REG_BOT_BLANK] <= RST_BOT_BLANK;
         for (int i = 0; i < COLOR_COUNT; i++) begin
            regs[REG_COLOR0 + 8'(i)] <= RST_COLOR[i];
         end
         regs[REG_STATUS]    <= 8'h00;
      end else if (apb_commit && pwrite_in && reg_hit && !reg_ro) begin
         regs[reg_idx] <= pwdata_in[7:0];
      end
   end

   // software may change any field at any time; the engine sees these via the shadow copy, but reads the on bit and colour registers live
   assign live_cfg.fixed_pattern_select   = regs[REG_CFG][CFG_FIXED_BIT]; // [R2]
   assign live_cfg.bar_count_code         = regs[REG_CFG][CFG_BARS_LSB +: 2];
   assign live_cfg.block_bytes            = regs[REG_CFG][CFG_BLOCK_LSB +: 4]; // [R4]
   assign live_cfg.packet_virtual_channel = regs[REG_IDENT][IDENT_VC_LSB +: 2];
   assign live_cfg.packet_data_type       = regs[REG_IDENT][IDENT_DT_LSB +: 6];
   assign live_cfg.active_line_bytes      = {regs[REG_LINE_HI], regs[REG_LINE_LO]};
   assign live_cfg.bar_bytes              = {regs[REG_BAR_HI], regs[REG_BAR_LO]};
   assign live_cfg.active_line_count      = {regs[REG_ACT_HI], regs[REG_ACT_LO]};
   assign live_cfg.frame_line_count       = {regs[REG_TOT_HI], regs[REG_TOT_LO]};
   assign live_cfg.line_period_count      = {regs[REG_PERIOD_HI], regs[REG_PERIOD_LO]};
   assign live_cfg.top_blank_lines        = regs[REG_TOP_BLANK];
   assign live_cfg.bottom_blank_lines     = regs[REG_BOT_BLANK];

   // ****************************************
   // frame geometry from the shadow copy
   // ****************************************
   assign video_first = {8'h00, shadow.top_blank_lines};
   assign video_end   = video_first + shadow.active_line_count;
   assign end_line    = video_end + {8'h00, shadow.bottom_blank_lines};
   assign video_line  = (line_idx >= video_first) && (line_idx < video_end);
   assign timer_done  = line_timer >= {1'b0, shadow.line_period_count};
   assign line_done   = timer_done && !sending && !begin_line;
   // a total shorter than the packet sequence still lets the frame end cleanly
   assign last_line   = (line_idx + 16'h0001 >= shadow.frame_line_count) &&
                        (line_idx >= end_line); // [R10]

   // ****************************************
   // frame sequencing
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state      <= ST_IDLE;
         line_idx   <= 16'h0000;
         begin_line <= 1'b0;
         shadow     <= '0;
      end else begin
         begin_line <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (regs[REG_CTL][CTL_ON_BIT]) begin // [R1]
                  state      <= ST_RUN;
                  line_idx   <= 16'h0000; // [R14]
                  shadow     <= live_cfg;
                  begin_line <= 1'b1;
               end
            end
            ST_RUN: begin
               if (line_done) begin
                  if (!last_line) begin
                     line_idx   <= line_idx + 16'h0001;
                     begin_line <= 1'b1;
                  end else if (regs[REG_CTL][CTL_ON_BIT]) begin
                     line_idx   <= 16'h0000; // [R14]
                     shadow     <= live_cfg;
                     begin_line <= 1'b1;
                  end else begin
                     // disabling lets the current frame finish, never a torn frame
                     state <= ST_IDLE; // [R1]
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // line period accumulates 10 ns units, five per clock
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         line_timer <= 17'h00000;
      end else if (begin_line) begin
         line_timer <= UNITS_PER_CLK; // [R11]
      end else if (state == ST_RUN && !timer_done) begin
         line_timer <= line_timer + UNITS_PER_CLK;
      end
   end

   // ****************************************
   // packet and byte output
   // ****************************************
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         sending    <= 1'b0;
         bytes_left <= 16'h0000;
         csi_out    <= '0;
      end else begin
         csi_out.frame_start     <= begin_line && line_idx == 16'h0000;
         csi_out.frame_end       <= begin_line && line_idx == end_line; // [R12]
         csi_out.line_start      <= begin_line && video_line; // [R9]
         csi_out.virtual_channel <= shadow.packet_virtual_channel; // [R5]
         csi_out.data_type       <= shadow.packet_data_type; // [R6]
         csi_out.word_count      <= shadow.active_line_bytes; // [R7]
         csi_out.data_valid      <= sending;
         csi_out.line_end        <= sending && bytes_left == 16'h0001;
         csi_out.data            <= sending ? regs[REG_COLOR0 + {5'h00, color_idx}]
                                            : 8'h00; // [R13]
         if (begin_line && video_line) begin
            sending    <= shadow.active_line_bytes != 16'h0000;
            bytes_left <= shadow.active_line_bytes;
         end else if (sending) begin
            bytes_left <= bytes_left - 16'h0001;
            sending    <= bytes_left != 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         running_out <= 1'b0;
      end else begin
         running_out <= (state == ST_RUN);
      end
   end

   pgen_position #(
      .IDX_W (3)
   ) u_position (
      .clk_in         (clk_in),
      .rst_n_in       (rst_n_in),
      .restart_in     (begin_line),
      .step_in        (sending),
      .fixed_in       (shadow.fixed_pattern_select), // [R2]
      .bar_code_in    (shadow.bar_count_code),
      .block_bytes_in (shadow.block_bytes), // [R4]
      .bar_bytes_in   (shadow.bar_bytes),
      .color_idx_out  (color_idx)
   );

   // ****************************************
   // checks
   // ****************************************
   property p_off_no_frame;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state == ST_IDLE && !regs[REG_CTL][CTL_ON_BIT]) |=> ##1 !csi_out.frame_start;
   endproperty
   a_off_no_frame: assert property (p_off_no_frame) // [R1]
      else $error("frame started while generator is off");

   property p_fixed_in_block;
      @(posedge clk_in) disable iff (!rst_n_in)
      (sending && shadow.fixed_pattern_select && shadow.block_bytes != 4'h0)
      |-> {1'b0, color_idx} < shadow.block_bytes;
   endproperty
   a_fixed_in_block: assert property (p_fixed_in_block) // [R4]
      else $error("fixed pattern index outside block");

   property p_header_fields;
      @(posedge clk_in) disable iff (!rst_n_in)
      csi_out.line_start |-> csi_out.virtual_channel == shadow.packet_virtual_channel &&
                             csi_out.data_type == shadow.packet_data_type;
   endproperty
   a_header_fields: assert property (p_header_fields) // [R5] [R6]
      else $error("packet header does not carry programmed identifier");

   property p_line_bytes;
      @(posedge clk_in) disable iff (!rst_n_in)
      (csi_out.line_start && csi_out.word_count == 16'h0003)
      |=> csi_out.data_valid [*3] ##1 !csi_out.data_valid;
   endproperty
   a_line_bytes: assert property (p_line_bytes) // [R7]
      else $error("short line did not carry its word count of bytes");

   property p_frame_start_line;
      @(posedge clk_in) disable iff (!rst_n_in)
      csi_out.frame_start |-> $past(line_idx) == 16'h0000 && $past(begin_line);
   endproperty
   a_frame_start_line: assert property (p_frame_start_line) // [R9]
      else $error("frame start outside line zero");

   property p_frame_end_line;
      @(posedge clk_in) disable iff (!rst_n_in)
      csi_out.frame_end |-> $past(line_idx) == $past(end_line);
   endproperty
   a_frame_end_line: assert property (p_frame_end_line) // [R12]
      else $error("frame end not after bottom blank lines");

   property p_line_timing;
      @(posedge clk_in) disable iff (!rst_n_in)
      (begin_line && $past(state) == ST_RUN && $past(line_done))
      |-> $past(line_timer) >= {1'b0, $past(shadow.line_period_count)};
   endproperty
   a_line_timing: assert property (p_line_timing) // [R11]
      else $error("line ended before its period");

   property p_cfg_at_boundary;
      @(posedge clk_in) disable iff (!rst_n_in)
      (shadow != $past(shadow)) |-> begin_line && line_idx == 16'h0000;
   endproperty
   a_cfg_at_boundary: assert property (p_cfg_at_boundary) // [R14]
      else $error("configuration changed inside a frame");

   property p_last_line_bound;
      @(posedge clk_in) disable iff (!rst_n_in)
      (state == ST_RUN && line_done && line_idx >= end_line &&
       line_idx + 16'h0001 >= shadow.frame_line_count)
      |=> (line_idx == 16'h0000 || state == ST_IDLE);
   endproperty
   a_last_line_bound: assert property (p_last_line_bound) // [R10]
      else $error("frame ran past its total line count");

   property p_bar_data;
      @(posedge clk_in) disable iff (!rst_n_in)
      sending |=> csi_out.data == $past(regs[REG_COLOR0 + {5'h00, color_idx}]);
   endproperty
   a_bar_data: assert property (p_bar_data) // [R13] [R15]
      else $error("byte not taken from selected colour register");

   property p_mode_bars;
      @(posedge clk_in) disable iff (!rst_n_in)
      (begin_line && video_line && !shadow.fixed_pattern_select) |=> color_idx == 3'h0;
   endproperty
   a_mode_bars: assert property (p_mode_bars) // [R2]
      else $error("line did not start on bar zero");

endmodule : pgen_top

// ---- pgen_sink.sv ----
// downstream receiver model: takes every stream cycle and records the first frame after clear
`timescale 1ns/1ps
module pgen_sink
   import pgen_pkg::*;
(
   input  wire logic                clk_in,
   input  wire logic                clear_in,
   input  pgen_pkg::csi_out_t       csi_in
);
   import pgen_pkg::*;
   logic [15:0] lines;
   logic [15:0] nbytes;
   logic [15:0] wc;
   logic [15:0] ends;
   logic [7:0]  ids_fs;
   logic [7:0]  ids_ls;
   logic        frames;
   logic [7:0]  cap [64];
   // ****************************************
   // capture
   // ****************************************
   // no back-pressure exists, so the model never stalls; later frames are ignored
   always @(posedge clk_in) begin
      if (clear_in) begin
         lines  <= 16'h0;
         nbytes <= 16'h0;
         frames <= 1'b0;
         ends   <= 16'h0;
      end else if (!frames) begin
         if (csi_in.frame_start) ids_fs <= {csi_in.virtual_channel, csi_in.data_type};
         if (csi_in.line_start) begin
            lines  <= lines + 16'h1;
            wc     <= csi_in.word_count;
            ids_ls <= {csi_in.virtual_channel, csi_in.data_type};
            nbytes <= 16'h0;
         end else if (csi_in.data_valid) begin
            cap[nbytes[5:0]] <= csi_in.data;
            nbytes           <= nbytes + 16'h1;
         end
         // byte position of the line end marker, counted from one
         if (csi_in.line_end) ends <= nbytes + 16'h1;
         if (csi_in.frame_end) frames <= 1'b1;
      end
   end
endmodule : pgen_sink

// ---- tb_top.sv ----
// self-checking bench: apb register checks and short generated frames
`timescale 1ns/1ps
module tb_top;
   import pgen_pkg::*;
   logic clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, clr = 1;
   logic [31:0] paddr_in = 0, pwdata_in = 0, rdata;
   logic        pready_out, pslverr_out, running_out, err, fx;
   logic [31:0] prdata_out;
   csi_out_t    csi;
   logic [1:0]  code, vc;
   logic [5:0]  dt;
   int          mismatches = 0, compares = 0, n, k, len, bar, blk;
   logic [7:0]  ridx [11] = '{REG_CTL, REG_CFG, REG_IDENT, REG_LINE_HI, REG_LINE_LO, REG_BAR_HI,
                              REG_BAR_LO, REG_ACT_HI, REG_ACT_LO, REG_TOT_HI, REG_TOT_LO};
   logic [7:0]  rval [11] = '{RST_CTL, RST_CFG, RST_IDENT, RST_LINE_HI, RST_LINE_LO, RST_BAR_HI,
                              RST_BAR_LO, RST_ACT_HI, RST_ACT_LO, RST_TOT_HI, RST_TOT_LO};
   // small frame: two active lines of six, shortest line period, one blank line each side
   logic [7:0]  sidx [10] = '{REG_LINE_HI, REG_BAR_HI, REG_ACT_HI, REG_ACT_LO, REG_TOT_HI,
                              REG_TOT_LO, REG_PERIOD_HI, REG_PERIOD_LO, REG_TOP_BLANK, REG_BOT_BLANK};
   logic [7:0]  sval [10] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h06, 8'h00, 8'h01, 8'h01, 8'h01};
   pgen_top u_pgen_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
      .csi_out(csi), .running_out(running_out));
   pgen_sink u_pgen_sink (.clk_in(clk_in), .clear_in(clr), .csi_in(csi));
   always #25 clk_in = ~clk_in;
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // entered just after a rising edge; leaves one idle edge so psel is never reassigned at once
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int w;
      w = 0;
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= {22'h0, idx, 2'b00};
      pwdata_in <= {24'h0, d};
      @(posedge clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge clk_in);
         w++;
      end while (pready_out !== 1'b1 && w < 20);
      rdata = prdata_out;
      err = pslverr_out;
      chk("pready", 1'b1, pready_out);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask : apb
   function automatic logic [7:0] exp_byte(int i);
      int c;
      c = fx ? (i % blk) % COLOR_COUNT : i / bar;
      if (!fx && c > (1 << code) - 1) c = (1 << code) - 1;
      return RST_COLOR[c];
   endfunction : exp_byte
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      #2500000;
      mismatches++;
      tally_and_finish();
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h58CA));
      repeat (3) @(posedge clk_in);
      rst_n_in <= 1'b1;
      clr <= 1'b0;
      repeat (30) @(posedge clk_in);
      chk("idle running", 1'b0, running_out);
      chk("idle lines", 16'h0, u_pgen_sink.lines);
      for (k = 0; k < 11; k++) begin
         apb(1'b0, ridx[k], 8'h00);
         chk("reset value", {24'h0, rval[k]}, rdata);
      end
      apb(1'b0, 8'h20, 8'h00);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped read", 32'h0, rdata);
      n = $urandom % 256;
      apb(1'b1, REG_PERIOD_HI, n[7:0]);
      apb(1'b0, REG_PERIOD_HI, 8'h00);
      chk("readback", n, rdata);
      for (k = 0; k < 10; k++) apb(1'b1, sidx[k], sval[k]);
      for (k = 0; k < 7; k++) begin
         fx = k >= 4;
         code = k[1:0];
         blk = k == 4 ? 15 : k == 5 ? 1 : 1 + $urandom % 15;
         bar = k == 0 ? 1 : 1 + $urandom % 12;
         len = k == 1 ? 3 : 8 + $urandom % 56; // a three byte line reaches the short line check
         vc = 2'($urandom);
         dt = 6'($urandom);
         apb(1'b1, REG_CFG, {fx, 1'b0, code, blk[3:0]});
         apb(1'b1, REG_IDENT, {vc, dt});
         apb(1'b1, REG_LINE_LO, len[7:0]);
         apb(1'b1, REG_BAR_LO, bar[7:0]);
         clr <= 1'b1;
         @(posedge clk_in);
         clr <= 1'b0;
         apb(1'b1, REG_CTL, 8'h01);
         for (n = 0; n < 5000 && u_pgen_sink.frames !== 1'b1; n++) @(posedge clk_in);
         apb(1'b1, REG_CTL, 8'h00);
         chk("frame end", 1'b1, u_pgen_sink.frames);
         chk("active lines", 16'd2, u_pgen_sink.lines);
         chk("word count", len, u_pgen_sink.wc);
         chk("line bytes", len, u_pgen_sink.nbytes);
         chk("line end", len, u_pgen_sink.ends);
         chk("line id", {vc, dt}, u_pgen_sink.ids_ls);
         chk("frame id", {vc, dt}, u_pgen_sink.ids_fs);
         for (n = 0; n < len; n++) chk("pixel byte", exp_byte(n), u_pgen_sink.cap[n]);
         for (n = 0; n < 5000 && running_out !== 1'b0; n++) @(posedge clk_in);
         chk("stopped", 1'b0, running_out);
      end
      tally_and_finish();
   end
endmodule : tb_top
